// *** inc/mid_cfg.svh ***
// Encoding, address and reset constants of the instruction decoder
`ifndef MID_CFG_SVH
`define MID_CFG_SVH

// Core clock periods per instruction cycle
`define MID_PHASE_COUNT  4

// Instruction classes in the top two bits
`define MID_CLS_BYTE     2'h0
`define MID_CLS_BIT      2'h1
`define MID_CLS_CTRL     2'h2
`define MID_CLS_LIT      2'h3

// Byte-oriented operation codes
`define MID_OP_MOVE_ACC  4'h0
`define MID_OP_CLEAR     4'h1
`define MID_OP_SUB       4'h2
`define MID_OP_DEC       4'h3
`define MID_OP_OR        4'h4
`define MID_OP_AND       4'h5
`define MID_OP_XOR       4'h6
`define MID_OP_ADD       4'h7
`define MID_OP_MOVE      4'h8
`define MID_OP_COM       4'h9
`define MID_OP_INC       4'ha
`define MID_OP_DEC_SKIP  4'hb
`define MID_OP_RR        4'hc
`define MID_OP_RL        4'hd
`define MID_OP_SWAP      4'he
`define MID_OP_INC_SKIP  4'hf

// Bit-oriented operation codes
`define MID_BIT_CLEAR    2'h0
`define MID_BIT_SET      2'h1
`define MID_BIT_TEST_CLR 2'h2
`define MID_BIT_TEST_SET 2'h3

// Literal operation codes and their don't-care prefixes
`define MID_LIT_OR       4'h8
`define MID_LIT_AND      4'h9
`define MID_LIT_XOR      4'ha
`define MID_LIT_LOAD2    2'h0
`define MID_LIT_RET2     2'h1
`define MID_LIT_SUB3     3'h6
`define MID_LIT_ADD3     3'h7

// Control words, low byte
`define MID_LO_RETURN    8'h08
`define MID_LO_INT_RET   8'h09
`define MID_LO_WDT_CLEAR 8'h64
`define MID_LO_STANDBY   8'h63

// Special file register addresses
`define MID_ADDR_TIMER   7'h01
`define MID_ADDR_PORT    7'h05

// Reset values
`define MID_RST_ACC      8'h00
`define MID_RST_TO       1'b1
`define MID_RST_PD       1'b1

`endif

// *** inc/mid_pkg.sv ***
// Types shared by the instruction decoder and its ALU
package mid_pkg;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COM, ALU_INC,
    ALU_DEC, ALU_RL, ALU_RR, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
  } mid_alu_op_t;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mid_phase_t;

  typedef struct packed {
    mid_phase_t  phase;
    logic [13:0] ir;
    logic        nopCur;
    logic        flushPend;
    logic [7:0]  acc;
    logic        carry;
    logic        digitCarry;
    logic        zero;
    logic        timeoutStatus;
    logic        powerdownStatus;
    logic [6:0]  regAddr;
    logic        regRd;
    logic        regWr;
    logic [7:0]  regWdata;
    logic        pcLoad;
    logic [10:0] pcTarget;
    logic        pushRet;
    logic        popRet;
    logic        intReturn;
    logic        skipFlush;
    logic        wdtClear;
    logic        standbyReq;
    logic        prescalerClear;
  } mid_state_t;

endpackage : mid_pkg

// *** inc/mid_alu_if.sv ***
// Operand and result bundle between decoder core and ALU
`timescale 1ns/1ps
interface mid_alu_if;
  import mid_pkg::*;
  mid_alu_op_t op;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        cin;
  logic [2:0]  bitIdx;
  logic [7:0]  res;
  logic        cOut;
  logic        dcOut;
  logic        zOut;

  modport core (output op, a, b, cin, bitIdx, input res, cOut, dcOut, zOut);
  modport alu  (input op, a, b, cin, bitIdx, output res, cOut, dcOut, zOut);
endinterface : mid_alu_if

// *** src/mid_alu.sv ***
// Eight-bit ALU of the instruction decoder
`timescale 1ns/1ps
`include "mid_cfg.svh"
module mid_alu (
  // Operands and results
  mid_alu_if.alu bus
);
  import mid_pkg::*;

  always_comb begin
    logic [8:0] sum9;
    logic [4:0] nib;
    logic [7:0] mask;
    sum9 = 9'h000;
    nib  = 5'h00;
    mask = 8'h01 << bus.bitIdx;
    bus.res   = bus.b;
    bus.cOut  = bus.cin;
    bus.dcOut = 1'b0;
    case (bus.op)
      ALU_ADD: begin
        sum9 = {1'b0, bus.a} + {1'b0, bus.b};
        nib  = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
        bus.res   = sum9[7:0];
        bus.cOut  = sum9[8];
        bus.dcOut = nib[4];
      end
      // Register or literal minus accumulator, carry means no borrow
      ALU_SUB: begin
        sum9 = {1'b0, bus.b} + {1'b0, ~bus.a} + 9'h001;
        nib  = {1'b0, bus.b[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
        bus.res   = sum9[7:0];
        bus.cOut  = sum9[8];
        bus.dcOut = nib[4];
      end
      ALU_AND:  bus.res = bus.a & bus.b;
      ALU_OR:   bus.res = bus.a | bus.b;
      ALU_XOR:  bus.res = bus.a ^ bus.b;
      ALU_COM:  bus.res = ~bus.b;
      ALU_INC:  bus.res = bus.b + 8'h01;
      ALU_DEC:  bus.res = bus.b - 8'h01;
      ALU_RL: begin
        bus.res  = {bus.b[6:0], bus.cin};
        bus.cOut = bus.b[7];
      end
      ALU_RR: begin
        bus.res  = {bus.cin, bus.b[7:1]};
        bus.cOut = bus.b[0];
      end
      ALU_SWAP: bus.res = {bus.b[3:0], bus.b[7:4]};
      ALU_CLR:  bus.res = 8'h00;
      ALU_BCLR: bus.res = bus.b & ~mask;
      ALU_BSET: bus.res = bus.b | mask;
      default:  bus.res = bus.b;
    endcase
    bus.zOut = (bus.res == 8'h00);
  end
endmodule : mid_alu

// *** src/mid_decoder.sv ***
// Four-phase instruction decoder and executor of a 14-bit word core
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "mid_cfg.svh"

// How it works
// - Every register operand read before written back
// - Destination bit zero accumulator, one register
// - Register address is low seven bits
// - Byte class 00, add/sub/swap codes decoded
// - Register OR/XOR/AND affect zero only
// - Rotates go through carry, change carry only
// - Decrement/increment skip on zero, flags kept
// - Clear register still reads it first
// - Bit class 01, op, index, address
// - Bit tests skip on matching polarity
// - Literal OR/AND/XOR affect zero only
// - Literal add/subtract ignore low bit, flags
// - Load literal, return with literal
// - Call/jump and taken tests flush one cycle
// - Return and interrupt return pop address
// - Watchdog clear restarts, sets status bits
// - Standby request updates status bits
// - Don't-care encoding bits are ignored
// - Port self-update uses pin levels
// - Timer write clears assigned prescaler
// - Instruction cycle is four core clocks
module mid_decoder (
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  // Instruction fetch
  input  wire logic [13:0] instrWord,
  // File register access
  output logic      [6:0]  regAddr,
  output logic             regRd,
  output logic             regWr,
  output logic      [7:0]  regWdata,
  input  wire logic [7:0]  regRdata,
  input  wire logic [7:0]  pinLevels,
  input  wire logic        prescalerOnTimer,
  // Program flow
  output logic             pcLoad,
  output logic      [10:0] pcTarget,
  output logic             pushRet,
  output logic             popRet,
  output logic             intReturn,
  output logic             skipFlush,
  // System
  output logic             wdtClear,
  output logic             standbyReq,
  output logic             prescalerClear,
  // Core state
  output logic      [1:0]  phase,
  output logic      [7:0]  acc,
  output logic             carry,
  output logic             digitCarry,
  output logic             zero,
  output logic             timeoutStatus,
  output logic             powerdownStatus
);
  import mid_pkg::*;

  // ****************************************************************
  // State and decode fields
  // ****************************************************************
  mid_state_t st_r;
  mid_state_t st_nxt;
  mid_alu_if  aluIf ();

  logic [1:0] insClass;
  logic [3:0] byteOp;
  logic       dBit;
  logic [7:0] literal;
  logic [2:0] bitIdx;
  logic [7:0] operand;
  logic       selBit;

  assign insClass = st_r.ir[13:12];
  assign byteOp   = st_r.ir[11:8];
  assign dBit     = st_r.ir[7];
  assign literal  = st_r.ir[7:0];
  assign bitIdx   = st_r.ir[9:7];
  assign operand  = (st_r.regAddr == `MID_ADDR_PORT) ? pinLevels : regRdata;
  assign selBit   = operand[bitIdx];

  mid_alu u_alu (
    .bus (aluIf.alu)
  );

  // Does this word name a file register
  function automatic logic namesReg(input logic [13:0] w);
    logic r;
    r = 1'b0;
    if (w[13:12] == `MID_CLS_BIT) begin
      r = 1'b1;
    end else if (w[13:12] == `MID_CLS_BYTE) begin
      if (w[11:8] == `MID_OP_MOVE_ACC || w[11:8] == `MID_OP_CLEAR) begin
        r = w[7];
      end else begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : namesReg

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic wrAcc;
    logic wrReg;
    logic upZ;
    logic upC;
    logic upDc;
    logic skip;
    wrAcc = 1'b0;
    wrReg = 1'b0;
    upZ   = 1'b0;
    upC   = 1'b0;
    upDc  = 1'b0;
    skip  = 1'b0;
    st_nxt = st_r;
    st_nxt.regRd          = 1'b0;
    st_nxt.regWr          = 1'b0;
    st_nxt.pcLoad         = 1'b0;
    st_nxt.pushRet        = 1'b0;
    st_nxt.popRet         = 1'b0;
    st_nxt.intReturn      = 1'b0;
    st_nxt.skipFlush      = 1'b0;
    st_nxt.wdtClear       = 1'b0;
    st_nxt.standbyReq     = 1'b0;
    st_nxt.prescalerClear = 1'b0;
    aluIf.op     = ALU_PASS;
    aluIf.a      = st_r.acc;
    aluIf.b      = operand;
    aluIf.cin    = st_r.carry;
    aluIf.bitIdx = bitIdx;

    case (st_r.phase)
      // Latch word, start the register read
      PH_Q1: begin
        st_nxt.phase     = PH_Q2;
        st_nxt.ir        = instrWord;
        st_nxt.nopCur    = st_r.flushPend;
        st_nxt.flushPend = 1'b0;
        st_nxt.regAddr   = instrWord[6:0];
        if (!st_r.flushPend && namesReg(instrWord)) begin
          st_nxt.regRd = 1'b1;
        end
      end
      PH_Q2: begin
        st_nxt.phase = PH_Q3;
      end
      // Read data valid: modify and schedule write
      PH_Q3: begin
        st_nxt.phase = PH_Q4;
        if (!st_r.nopCur) begin
          case (insClass)
            `MID_CLS_BYTE: begin
              wrAcc = !dBit;
              wrReg = dBit;
              case (byteOp)
                `MID_OP_MOVE_ACC: begin
                  wrAcc = 1'b0;
                  aluIf.b = st_r.acc;
                  if (!dBit) begin
                    case (literal)
                      `MID_LO_RETURN: begin
                        st_nxt.popRet = 1'b1;
                        skip = 1'b1;
                      end
                      `MID_LO_INT_RET: begin
                        st_nxt.popRet    = 1'b1;
                        st_nxt.intReturn = 1'b1;
                        skip = 1'b1;
                      end
                      `MID_LO_WDT_CLEAR: begin
                        st_nxt.wdtClear        = 1'b1;
                        st_nxt.timeoutStatus   = 1'b1;
                        st_nxt.powerdownStatus = 1'b1;
                      end
                      `MID_LO_STANDBY: begin
                        st_nxt.standbyReq      = 1'b1;
                        st_nxt.timeoutStatus   = 1'b1;
                        st_nxt.powerdownStatus = 1'b0;
                      end
                      default: ;
                    endcase
                  end
                end
                `MID_OP_CLEAR: begin
                  aluIf.op = ALU_CLR;
                  upZ = 1'b1;
                end
                `MID_OP_SUB: begin
                  aluIf.op = ALU_SUB;
                  {upC, upDc, upZ} = 3'h7;
                end
                `MID_OP_ADD: begin
                  aluIf.op = ALU_ADD;
                  {upC, upDc, upZ} = 3'h7;
                end
                `MID_OP_DEC: begin
                  aluIf.op = ALU_DEC;
                  upZ = 1'b1;
                end
                `MID_OP_INC: begin
                  aluIf.op = ALU_INC;
                  upZ = 1'b1;
                end
                `MID_OP_OR: begin
                  aluIf.op = ALU_OR;
                  upZ = 1'b1;
                end
                `MID_OP_AND: begin
                  aluIf.op = ALU_AND;
                  upZ = 1'b1;
                end
                `MID_OP_XOR: begin
                  aluIf.op = ALU_XOR;
                  upZ = 1'b1;
                end
                `MID_OP_MOVE: begin
                  upZ = 1'b1;
                end
                `MID_OP_COM: begin
                  aluIf.op = ALU_COM;
                  upZ = 1'b1;
                end
                `MID_OP_DEC_SKIP: begin
                  aluIf.op = ALU_DEC;
                  skip = aluIf.zOut;
                end
                `MID_OP_INC_SKIP: begin
                  aluIf.op = ALU_INC;
                  skip = aluIf.zOut;
                end
                `MID_OP_RR: begin
                  aluIf.op = ALU_RR;
                  upC = 1'b1;
                end
                `MID_OP_RL: begin
                  aluIf.op = ALU_RL;
                  upC = 1'b1;
                end
                `MID_OP_SWAP: begin
                  aluIf.op = ALU_SWAP;
                end
                default: ;
              endcase
            end
            `MID_CLS_BIT: begin
              case (st_r.ir[11:10])
                `MID_BIT_CLEAR: begin
                  aluIf.op = ALU_BCLR;
                  wrReg = 1'b1;
                end
                `MID_BIT_SET: begin
                  aluIf.op = ALU_BSET;
                  wrReg = 1'b1;
                end
                `MID_BIT_TEST_CLR: skip = !selBit;
                `MID_BIT_TEST_SET: skip = selBit;
                default: ;
              endcase
            end
            `MID_CLS_CTRL: begin
              st_nxt.pcLoad   = 1'b1;
              st_nxt.pcTarget = st_r.ir[10:0];
              st_nxt.pushRet  = !st_r.ir[11];
              skip = 1'b1;
            end
            default: begin
              wrAcc   = 1'b1;
              aluIf.b = literal;
              if (byteOp[3:2] == `MID_LIT_LOAD2) begin
                aluIf.op = ALU_PASS;
              end else if (byteOp[3:2] == `MID_LIT_RET2) begin
                st_nxt.popRet = 1'b1;
                skip = 1'b1;
              end else if (byteOp[3:1] == `MID_LIT_SUB3) begin
                aluIf.op = ALU_SUB;
                {upC, upDc, upZ} = 3'h7;
              end else if (byteOp[3:1] == `MID_LIT_ADD3) begin
                aluIf.op = ALU_ADD;
                {upC, upDc, upZ} = 3'h7;
              end else if (byteOp == `MID_LIT_OR) begin
                aluIf.op = ALU_OR;
                upZ = 1'b1;
              end else if (byteOp == `MID_LIT_AND) begin
                aluIf.op = ALU_AND;
                upZ = 1'b1;
              end else if (byteOp == `MID_LIT_XOR) begin
                aluIf.op = ALU_XOR;
                upZ = 1'b1;
              end else begin
                wrAcc = 1'b0;
              end
            end
          endcase

          if (wrAcc) begin
            st_nxt.acc = aluIf.res;
          end
          if (wrReg) begin
            st_nxt.regWr    = 1'b1;
            st_nxt.regWdata = aluIf.res;
            if (st_r.regAddr == `MID_ADDR_TIMER && prescalerOnTimer) begin
              st_nxt.prescalerClear = 1'b1;
            end
          end
          if (upZ) begin
            st_nxt.zero = aluIf.zOut;
          end
          if (upC) begin
            st_nxt.carry = aluIf.cOut;
          end
          if (upDc) begin
            st_nxt.digitCarry = aluIf.dcOut;
          end
          if (skip) begin
            st_nxt.flushPend = 1'b1;
            st_nxt.skipFlush = 1'b1;
          end
        end
      end
      PH_Q4: begin
        st_nxt.phase = PH_Q1;
      end
      default: begin
        st_nxt.phase = PH_Q1;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r                 <= '0;
      st_r.acc             <= `MID_RST_ACC;
      st_r.timeoutStatus   <= `MID_RST_TO;
      st_r.powerdownStatus <= `MID_RST_PD;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign regAddr         = st_r.regAddr;
  assign regRd           = st_r.regRd;
  assign regWr           = st_r.regWr;
  assign regWdata        = st_r.regWdata;
  assign pcLoad          = st_r.pcLoad;
  assign pcTarget        = st_r.pcTarget;
  assign pushRet         = st_r.pushRet;
  assign popRet          = st_r.popRet;
  assign intReturn       = st_r.intReturn;
  assign skipFlush       = st_r.skipFlush;
  assign wdtClear        = st_r.wdtClear;
  assign standbyReq      = st_r.standbyReq;
  assign prescalerClear  = st_r.prescalerClear;
  assign phase           = st_r.phase;
  assign acc             = st_r.acc;
  assign carry           = st_r.carry;
  assign digitCarry      = st_r.digitCarry;
  assign zero            = st_r.zero;
  assign timeoutStatus   = st_r.timeoutStatus;
  assign powerdownStatus = st_r.powerdownStatus;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Stalled edges are no ticks, so past values follow the state
  default clocking cb @(posedge mclk iff clkEn);
  endclocking
  default disable iff (srst || !clkEn);

  AST_WRITE_AFTER_READ: assert property (
    st_r.regWr |-> $past(st_r.regRd, 2)
  ) else $error("register written without prior read");

  AST_FOUR_PHASES: assert property (
    st_r.phase == PH_Q1 |=> st_r.phase == PH_Q2 ##1 st_r.phase == PH_Q3
      ##1 st_r.phase == PH_Q4 ##1 st_r.phase == PH_Q1
  ) else $error("instruction cycle not four clocks");

  AST_DEST_ACC: assert property (
    (st_r.phase == PH_Q4 && !st_r.nopCur && insClass == `MID_CLS_BYTE
      && byteOp != `MID_OP_MOVE_ACC && !dBit) |-> !st_r.regWr
  ) else $error("accumulator destination wrote register");

  AST_LIT_ZERO: assert property (
    (st_r.phase == PH_Q4 && !st_r.nopCur && insClass == `MID_CLS_LIT
      && byteOp == `MID_LIT_OR) |-> st_r.zero == (st_r.acc == 8'h00)
  ) else $error("zero flag disagrees with result");

  AST_SKIP_FLUSH: assert property (
    st_r.skipFlush |=> st_r.phase == PH_Q1 ##1 st_r.nopCur && !st_r.regRd
  ) else $error("taken branch did not flush next word");

  AST_CLEAR_READS: assert property (
    (st_r.regWr && st_r.ir[13:7] == 7'h03) |->
      st_r.regWdata == 8'h00 && $past(st_r.regRd, 2) && st_r.zero
  ) else $error("register clear wrong");

  AST_PRESCALER: assert property (
    st_r.prescalerClear |-> st_r.regWr && st_r.regAddr == `MID_ADDR_TIMER
  ) else $error("prescaler clear without timer write");

  AST_TEST_NO_WRITE: assert property (
    (st_r.phase == PH_Q4 && insClass == `MID_CLS_BIT && st_r.ir[11])
      |-> !st_r.regWr && $stable(st_r.zero)
  ) else $error("bit test wrote register or flags");

  AST_STANDBY: assert property (
    st_r.standbyReq |-> st_r.timeoutStatus && !st_r.powerdownStatus
  ) else $error("standby status bits wrong");

endmodule : mid_decoder

// *** verification/mid_decoder_tb.sv ***
// Self-checking bench of the instruction decoder
`timescale 1ns/1ps
`include "mid_cfg.svh"
module mid_decoder_tb;
  import mid_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [6:0]  addr;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  acc;
    logic [4:0]  flg;
    logic [7:0]  ctl;
    logic [10:0] pcT;
  } mid_tb_exp_t;
  logic        mclk, srst, clkEn, regRd, regWr, prescalerOnTimer, pcLoad, pushRet;
  logic        popRet, intReturn, skipFlush, wdtClear, standbyReq, prescalerClear;
  logic        carry, digitCarry, zero, timeoutStatus, powerdownStatus, seenRd;
  logic        mC, mDc, mZ, mTo, mPd, mFl;
  logic [13:0] instrWord;
  logic [6:0]  regAddr, seenAddr;
  logic [7:0]  regWdata, regRdata, pinLevels, acc, mAcc;
  logic [10:0] pcTarget;
  logic [1:0]  phase;
  mid_tb_exp_t expQ[$];
  mid_tb_exp_t got;
  int          seed, failures, totalChecks, cycles;
  logic [13:0] ctlW [12] = '{14'h0008, 14'h0009, 14'h0064, 14'h0063, 14'h0060, 14'h0020,
                             14'h0040, 14'h017f, 14'h2123, 14'h2a55, 14'h3400, 14'h3b00};

  mid_decoder i_mid_decoder (.mclk(mclk), .srst(srst), .clkEn(clkEn), .instrWord(instrWord),
    .regAddr(regAddr), .regRd(regRd), .regWr(regWr), .regWdata(regWdata),
    .regRdata(regRdata), .pinLevels(pinLevels), .prescalerOnTimer(prescalerOnTimer),
    .pcLoad(pcLoad), .pcTarget(pcTarget), .pushRet(pushRet), .popRet(popRet),
    .intReturn(intReturn), .skipFlush(skipFlush), .wdtClear(wdtClear),
    .standbyReq(standbyReq), .prescalerClear(prescalerClear), .phase(phase), .acc(acc),
    .carry(carry), .digitCarry(digitCarry), .zero(zero), .timeoutStatus(timeoutStatus),
    .powerdownStatus(powerdownStatus));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************
  // Checking
  // ****************
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic finishTest;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finishTest

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finishTest;
    end
  end

  always @(posedge mclk) begin
    if (!srst && clkEn && phase == 2'h1) begin
      seenRd <= regRd;
      seenAddr <= regAddr;
    end
    if (!srst && clkEn && phase == 2'h3) begin
      if (expQ.size() == 0) chk("queue", 11'h0, 11'h1);
      got = expQ.pop_front();
      chk("regRd", 11'(got.rd), 11'(seenRd));
      if (got.rd) chk("regAddr", 11'(got.addr), 11'(seenAddr));
      chk("regWr", 11'(got.wr), 11'(regWr));
      if (got.wr) chk("regWdata", 11'(got.wdata), 11'(regWdata));
      chk("acc", 11'(got.acc), 11'(acc));
      chk("flags", 11'(got.flg),
          11'({carry, digitCarry, zero, timeoutStatus, powerdownStatus}));
      chk("ctl", 11'(got.ctl),
          11'({pcLoad, pushRet, popRet, intReturn, skipFlush, wdtClear, standbyReq,
               prescalerClear}));
      if (got.ctl[7]) chk("pcTarget", got.pcT, pcTarget);
    end
  end

  // ****************
  // Driving
  // ****************
  task automatic step;
    do begin
      clkEn <= ($random(seed) & 7) != 0;
      @(posedge mclk);
    end while (!clkEn);
  endtask : step

  task automatic addsub(input logic [7:0] a, input logic sub, output logic [7:0] r);
    mC = sub ? a >= mAcc : {1'b0, a} + {1'b0, mAcc} > 9'h0ff;
    mDc = sub ? a[3:0] >= mAcc[3:0] : {1'b0, a[3:0]} + {1'b0, mAcc[3:0]} > 5'h0f;
    r = sub ? a - mAcc : a + mAcc;
  endtask : addsub

  task automatic run(input logic [13:0] w, input logic [7:0] rd);
    mid_tb_exp_t e;
    logic [7:0]  f;
    logic [7:0]  r;
    logic [7:0]  pin;
    logic [3:0]  op;
    logic        pot;
    logic        fl;
    pin = 8'($random(seed));
    pot = 1'($random(seed));
    f = (w[6:0] == `MID_ADDR_PORT) ? pin : rd;
    op = w[11:8];
    e = '0;
    fl = 1'b0;
    if (mFl) begin
      mFl = 1'b0;
    end else begin
      case (w[13:12])
        2'h0: begin
          e.rd = w[7] || op > 4'h1;
          case (op)
            4'h0: r = mAcc;
            4'h1: r = 8'h00;
            4'h2: addsub(f, 1'b1, r);
            4'h3, 4'hb: r = f - 8'h01;
            4'h4: r = f | mAcc;
            4'h5: r = f & mAcc;
            4'h6: r = f ^ mAcc;
            4'h7: addsub(f, 1'b0, r);
            4'h8: r = f;
            4'h9: r = ~f;
            4'hc: r = {mC, f[7:1]};
            4'hd: r = {f[6:0], mC};
            4'he: r = {f[3:0], f[7:4]};
            default: r = f + 8'h01;
          endcase
          if (op == 4'hc) mC = f[0];
          if (op == 4'hd) mC = f[7];
          if (!(op inside {4'h0, [4'hb:4'hf]})) mZ = r == 8'h00;
          fl = op inside {4'hb, 4'hf} && r == 8'h00;
          e.wr = w[7];
          e.wdata = r;
          if (!w[7] && op != 4'h0) mAcc = r;
          if (op == 4'h0 && !w[7]) begin
            case (w[7:0])
              8'h08: e.ctl = 8'h20;
              8'h09: e.ctl = 8'h30;
              8'h64: e.ctl = 8'h04;
              8'h63: e.ctl = 8'h02;
              default: ;
            endcase
            fl = w[7:0] inside {8'h08, 8'h09};
            if (w[7:0] inside {8'h63, 8'h64}) begin
              mTo = 1'b1;
              mPd = w[2];
            end
          end
        end
        2'h1: begin
          e.rd = 1'b1;
          r = f;
          r[w[9:7]] = w[10];
          e.wr = !w[11];
          e.wdata = r;
          fl = w[11] && f[w[9:7]] == w[10];
        end
        2'h2: begin
          e.ctl = w[11] ? 8'h80 : 8'hc0;
          e.pcT = w[10:0];
          fl = 1'b1;
        end
        default: begin
          case (op)
            4'h8: mAcc = mAcc | w[7:0];
            4'h9: mAcc = mAcc & w[7:0];
            4'ha: mAcc = mAcc ^ w[7:0];
            4'hb: ;
            4'hc, 4'hd: addsub(w[7:0], 1'b1, mAcc);
            4'he, 4'hf: addsub(w[7:0], 1'b0, mAcc);
            default: mAcc = w[7:0];
          endcase
          if (op inside {[4'h8:4'ha], [4'hc:4'hf]}) mZ = mAcc == 8'h00;
          fl = w[11:10] == 2'h1;
          if (fl) e.ctl = 8'h20;
        end
      endcase
      e.addr = w[6:0];
      e.ctl[0] = e.wr && w[6:0] == `MID_ADDR_TIMER && pot;
      e.ctl[3] = fl;
      mFl = fl;
    end
    e.acc = mAcc;
    e.flg = {mC, mDc, mZ, mTo, mPd};
    expQ.push_back(e);
    instrWord <= w;
    pinLevels <= pin;
    prescalerOnTimer <= pot;
    regRdata <= ~rd;
    step;
    instrWord <= ~w;
    step;
    regRdata <= rd;
    step;
    regRdata <= ~rd;
    step;
  endtask : run

  task automatic doReset;
    srst <= 1'b1;
    clkEn <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    chk("rstAcc", 11'h0, 11'(acc));
    chk("rstFlags", 11'h3,
        11'({carry, digitCarry, zero, timeoutStatus, powerdownStatus}));
    chk("rstPhase", 11'h0, 11'(phase));
    {mAcc, mC, mDc, mZ, mTo, mPd, mFl} = {8'h00, 5'h03, 1'b0};
  endtask : doReset

  initial begin
    logic [13:0] w;
    seed = 32'he0bc;
    {srst, clkEn, instrWord, regRdata, pinLevels, prescalerOnTimer} = {2'h3, 31'h0};
    doReset;
    for (int i = 0; i < 128; i++) begin
      if (i[4:0] != 5'h0) run({2'h0, i[4:0], i[6], 3'h0, i[5], 2'h1}, 8'($random(seed)));
    end
    for (int i = 0; i < 64; i++) begin
      run({2'h1, i[1:0], i[4:2], i[5], 6'h23}, 8'($random(seed)));
    end
    run(14'h0b20, 8'h01);
    run(14'h3f77, 8'h00);
    run(14'h0fa0, 8'hff);
    run(14'h0081, 8'h00);
    foreach (ctlW[i]) begin
      run(ctlW[i], 8'h5a);
      run({2'h3, i[3:0], 8'($random(seed))}, 8'h00);
      run({2'h3, ~i[3:0], 8'($random(seed))}, 8'h00);
    end
    for (int i = 0; i < 400; i++) begin
      w = 14'($random(seed));
      if (w[13:7] == 7'h0) w[6:0] = w[6:0] & 7'h60;
      run(w, 8'($random(seed)));
    end
    run(14'h0063, 8'h00);
    doReset;
    run(14'h0081, 8'h00);
    finishTest;
  end
endmodule : mid_decoder_tb
